// ==== design/irct_params.svh ====
// Purpose: constants of the infrared carrier and envelope timer block
// Assumes: register index times four gives the APB byte address
// Notes:   definitions only
`ifndef IRCT_PARAMS_SVH
`define IRCT_PARAMS_SVH
// ==========================================================
// register indices
`define IRCT_IDX_MODE      8'h20  // timer mode select
`define IRCT_IDX_CA_CTRL   8'h21  // carrier timer control
`define IRCT_IDX_ENV_CTRL  8'h22  // envelope timer control
`define IRCT_IDX_CA_CNT    8'h23  // live count / period preload
`define IRCT_IDX_CA_HIGH   8'h24  // carrier high pulse
`define IRCT_IDX_ENV_LO    8'h25  // envelope count / preload low
`define IRCT_IDX_ENV_HI    8'h26  // envelope count / preload high
`define IRCT_IDX_IR_CTRL   8'h17  // infrared output disable
`define IRCT_IDX_DRIVE     8'h11  // transmit drive control
`define IRCT_IDX_STATUS    8'h29  // overflow flags, write one to clear
// ==========================================================
// field positions
`define IRCT_BIT_DOWN      7      // down-count mode select
`define IRCT_BIT_EN        7      // timer enable in both control regs
`define IRCT_BIT_SEL_HI    5      // clock select field top
`define IRCT_BIT_SEL_LO    4      // clock select field bottom
`define IRCT_BIT_MODE      0      // carrier-free mode bit
`define IRCT_BIT_IR_DIS    6      // infrared output disable
`define IRCT_BIT_DRIVE     3      // drive strength
`define IRCT_BIT_ENV_FLAG  0      // envelope overflow flag
`define IRCT_BIT_CA_FLAG   1      // carrier overflow flag
// ==========================================================
// reset values and limits
`define IRCT_RST_BYTE      8'h00
`define IRCT_RST_ENV       12'h000
`define IRCT_CA_MIN        8'h00
`define IRCT_ENV_MIN       12'h000
`define IRCT_PRE_W         6      // prescaler width, reaches divide by 64
`endif

// ==== design/irct_pkg.sv ====
// Purpose: types of the infrared carrier and envelope timer block
// Assumes: constants live in irct_params.svh
// Notes:   no imports, use irct_pkg::name
package irct_pkg;
  // ==========================================================
  // types
  typedef enum logic {IRCT_IDLE, IRCT_RUN} irct_run_t;     // timer run state
  typedef logic [1:0]                    irct_sel_t;     // clock select field
endpackage

// ==== design/irct_top.sv ====
// Purpose: carrier (8-bit) and envelope (12-bit) down-count timers driving the infrared pin
// Assumes: APB slave, one 25 MHz clock, synchronous active high reset
// Notes:   the up-count mode is not built; timers hold while it is selected
// Notes:   each register is one byte in the low byte of its word
`timescale 1ns/100ps
`include "irct_params.svh"

// Behaviour
// RULE1: down-count mode runs 8-bit and 12-bit counters
// RULE2: carrier clock: osc, /2, /4, /16
// RULE3: start loads period and high value
// RULE4: output starts low, high on compare match
// RULE5: overflow drives low and reloads both
// RULE6: carrier overflow when count wraps 00 to FF
// RULE7: non-carrier envelope clock: enable bit gates output
// RULE8: disable bit suppresses infrared output
// RULE9: carrier envelope toggles only at envelope overflows
// RULE10: software sequences envelope on and off counts
// RULE11: carrier-free pin shows static gated level
// RULE12: carrier-free mode reloads only period value
// RULE13: mode bit zero carrier, one level held high
// RULE14: carrier control bit 7 enables, resets zero
// RULE15: count address reads count, write sets period
// RULE16: high pulse register read/write duty value
// RULE17: envelope clock: osc, /4, /64, carrier
// RULE18: envelope overflow reloads and sets flag
// RULE19: envelope overflows when wrapping 000 to FFF
// RULE20: envelope control bit 7 enables, resets zero
// RULE21: envelope addresses read count, write preload
// RULE22: drive bit selects half or full current
// RULE23: carrier overflow is one envelope count
module irct_top (
  input  wire logic        mclk_i,                    // 25 MHz clock
  input  wire logic        reset_i,                   // synchronous, active high
  input  wire logic        psel_i,                    // apb select
  input  wire logic        penable_i,                 // apb access phase
  input  wire logic        pwrite_i,                  // apb direction
  input  wire logic [11:0] paddr_i,                   // apb byte address
  input  wire logic [31:0] pwdata_i,                  // apb write data
  output logic      [31:0] prdata_o,                  // apb read data
  output logic             pready_o,                  // apb ready
  output logic             pslverr_o,                 // apb error
  output logic             infrared_transmit_pin_o,   // to the led driver
  output logic             transmit_drive_strength_o, // 0 half, 1 full current
  output logic             carrier_overflow_o,        // one-cycle pulse
  output logic             envelope_overflow_flag_o   // sticky flag
);
  // ==========================================================
  // functions
  // one address map shared by read mux, writes
  // and status clear, so they cannot disagree
  // address hit on a register index, word aligned only
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:10] == 2'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  // one-cycle enable from the free prescaler for a divider of 2**k
  // one shared prescaler: a new clock select
  // never waits for a private divider
  function automatic logic pre_tick(input logic [`IRCT_PRE_W-1:0] p, input int k);
    logic [`IRCT_PRE_W-1:0] m;
    m        = ((`IRCT_PRE_W)'(1) << k) - (`IRCT_PRE_W)'(1);
    pre_tick = ((p & m) == m);
  endfunction

  // ==========================================================
  // registers
  logic [7:0]               mode_sel_r;     // bit 7 selects down count
  logic [7:0]               ca_ctrl_r;      // carrier control
  logic [7:0]               env_ctrl_r;     // envelope control
  logic [7:0]               ca_period_r;    // carrier period preload
  logic [7:0]               ca_high_r;      // carrier high pulse preload
  logic [11:0]              env_pre_r;      // envelope preload

  // pin side controls
  logic                     ir_dis_r;       // infrared output disable
  logic                     drive_r;        // drive strength
  logic                     env_flag_r;     // sticky envelope overflow
  logic                     ca_flag_r;      // sticky carrier overflow

  // counting state, also the live read values
  logic [`IRCT_PRE_W-1:0]   pre_r;          // free prescaler
  logic [7:0]               ca_cnt_r;       // carrier down counter
  logic [7:0]               ca_cmp_r;       // compare unit
  logic                     carrier_r;      // internal carrier
  logic [11:0]              env_cnt_r;      // envelope down counter
  logic                     env_on_r;       // envelope on phase
  irct_pkg::irct_run_t      ca_run_r;       // carrier started
  irct_pkg::irct_run_t      env_run_r;      // envelope started

  // flops behind every output
  logic                     ca_ovf_r;       // carrier overflow pulse
  logic [31:0]              rdata_r;        // registered read data
  logic                     ready_r;        // registered ready
  logic                     err_r;          // registered error
  logic                     pin_r;          // registered pin level

  // ==========================================================
  // decoding
  // timers run only in down-count mode
  wire       down_mode  = mode_sel_r[`IRCT_BIT_DOWN];
  wire       ca_en      = ca_ctrl_r[`IRCT_BIT_EN] && down_mode;
  wire       env_en     = env_ctrl_r[`IRCT_BIT_EN] && down_mode;
  wire       level_mode = ca_ctrl_r[`IRCT_BIT_MODE];
  wire irct_pkg::irct_sel_t ca_sel  = ca_ctrl_r[`IRCT_BIT_SEL_HI:`IRCT_BIT_SEL_LO];
  wire irct_pkg::irct_sel_t env_sel = env_ctrl_r[`IRCT_BIT_SEL_HI:`IRCT_BIT_SEL_LO];
  wire       env_by_ca  = (env_sel == 2'h3);

  // bus qualifiers; a write lands at its completing edge
  wire       access     = psel_i && penable_i;
  wire       wr_commit  = access && pwrite_i && ready_r && !err_r;
  wire       w1c        = access && pwrite_i && ready_r && hit(paddr_i, `IRCT_IDX_STATUS);
  wire       in_range   = (paddr_i[11:2] >= 10'(`IRCT_IDX_MODE)) && (paddr_i[11:2] <= 10'(`IRCT_IDX_ENV_HI));
  wire       mapped     = (in_range && (paddr_i[1:0] == 2'h0)) || hit(paddr_i, `IRCT_IDX_IR_CTRL)
                          || hit(paddr_i, `IRCT_IDX_DRIVE) || hit(paddr_i, `IRCT_IDX_STATUS);

  // slower rates are enables, never derived clocks
  // carrier count enable from the selected division
  wire ca_tick = (ca_sel == 2'h0) ? 1'b1 :                              // see RULE2
                 (ca_sel == 2'h1) ? pre_tick(pre_r, 1) :
                 (ca_sel == 2'h2) ? pre_tick(pre_r, 2) : pre_tick(pre_r, 4);
  wire ca_start = ca_en && (ca_run_r == irct_pkg::IRCT_IDLE);           // see RULE3
  wire ca_step  = ca_en && (ca_run_r == irct_pkg::IRCT_RUN) && ca_tick;
  wire ca_wrap  = ca_step && (ca_cnt_r == `IRCT_CA_MIN);                // see RULE6
  wire [7:0] ca_dec = ca_cnt_r - 8'h01;

  // envelope count enable; by carrier it counts carrier periods
  // carrier wrap as event: one count per period
  wire env_tick = (env_sel == 2'h0) ? 1'b1 :                            // see RULE17
                  (env_sel == 2'h1) ? pre_tick(pre_r, 2) :
                  (env_sel == 2'h2) ? pre_tick(pre_r, 6) : ca_wrap;     // see RULE23
  wire env_start = env_en && (env_run_r == irct_pkg::IRCT_IDLE);
  wire env_step  = env_en && (env_run_r == irct_pkg::IRCT_RUN) && env_tick;
  wire env_wrap  = env_step && (env_cnt_r == `IRCT_ENV_MIN);            // see RULE19

  // on/off gate: envelope phase when carrier clocks it, else enable bit
  // the disable bit wins over every mode
  wire gate    = (env_by_ca && env_en) ? env_on_r : ca_en;              // see RULE7 RULE9
  wire pin_nxt = ir_dis_r ? 1'b0 :                                      // see RULE8
                 level_mode ? gate :                                    // see RULE11 RULE13
                 (carrier_r && gate);

  // read multiplexer
  // count addresses read live counters; a new
  // preload shows only after a start or wrap
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = `IRCT_RST_BYTE;
    if (hit(paddr_i, `IRCT_IDX_MODE))     rd_byte = mode_sel_r;
    if (hit(paddr_i, `IRCT_IDX_CA_CTRL))  rd_byte = ca_ctrl_r & 8'hB1;
    if (hit(paddr_i, `IRCT_IDX_ENV_CTRL)) rd_byte = env_ctrl_r & 8'hB0;
    if (hit(paddr_i, `IRCT_IDX_CA_CNT))   rd_byte = ca_cnt_r;                // see RULE15
    if (hit(paddr_i, `IRCT_IDX_CA_HIGH))  rd_byte = ca_high_r;               // see RULE16
    if (hit(paddr_i, `IRCT_IDX_ENV_LO))   rd_byte = env_cnt_r[7:0];          // see RULE21
    if (hit(paddr_i, `IRCT_IDX_ENV_HI))   rd_byte = {4'h0, env_cnt_r[11:8]};
    if (hit(paddr_i, `IRCT_IDX_IR_CTRL))  rd_byte = {1'b0, ir_dis_r, 6'h00};
    if (hit(paddr_i, `IRCT_IDX_DRIVE))    rd_byte = {4'h0, drive_r, 3'h0};
    if (hit(paddr_i, `IRCT_IDX_STATUS))   rd_byte = {6'h00, ca_flag_r, env_flag_r};
  end

  // ==========================================================
  // apb slave: one wait state so read data comes from a flop
  // trade-off: one extra cycle per access, but
  // no path from address decode to prdata
  // unmapped or misaligned: error, no write
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ready_r <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ready_r <= access && !ready_r;
      err_r   <= access && !ready_r && !mapped;     // unmapped answers error
      rdata_r <= (access && !ready_r) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // software registers, written at the completing edge
  // reserved bits masked, so they read zero
  // period shares its address with live count
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mode_sel_r  <= `IRCT_RST_BYTE;
      ca_ctrl_r   <= `IRCT_RST_BYTE;                // see RULE14
      env_ctrl_r  <= `IRCT_RST_BYTE;                // see RULE20
      ca_period_r <= `IRCT_RST_BYTE;
      ca_high_r   <= `IRCT_RST_BYTE;
      env_pre_r   <= `IRCT_RST_ENV;
      ir_dis_r    <= 1'b0;
      drive_r     <= 1'b0;
    end else if (wr_commit) begin
      if (hit(paddr_i, `IRCT_IDX_MODE))     mode_sel_r  <= pwdata_i[7:0] & 8'h80;  // see RULE1
      if (hit(paddr_i, `IRCT_IDX_CA_CTRL))  ca_ctrl_r   <= pwdata_i[7:0] & 8'hB1;
      if (hit(paddr_i, `IRCT_IDX_ENV_CTRL)) env_ctrl_r  <= pwdata_i[7:0] & 8'hB0;
      if (hit(paddr_i, `IRCT_IDX_CA_CNT))   ca_period_r <= pwdata_i[7:0];          // see RULE15
      if (hit(paddr_i, `IRCT_IDX_CA_HIGH))  ca_high_r   <= pwdata_i[7:0];          // see RULE16
      if (hit(paddr_i, `IRCT_IDX_ENV_LO))   env_pre_r[7:0]  <= pwdata_i[7:0];      // see RULE21
      if (hit(paddr_i, `IRCT_IDX_ENV_HI))   env_pre_r[11:8] <= pwdata_i[3:0];
      if (hit(paddr_i, `IRCT_IDX_IR_CTRL))  ir_dis_r    <= pwdata_i[`IRCT_BIT_IR_DIS];
      if (hit(paddr_i, `IRCT_IDX_DRIVE))    drive_r     <= pwdata_i[`IRCT_BIT_DRIVE];  // see RULE22
    end
  end

  // sticky flags: a new overflow wins over a clear in the same cycle
  // cleared by writing one to the status bit
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      env_flag_r <= 1'b0;
      ca_flag_r  <= 1'b0;
    end else begin
      env_flag_r <= env_wrap || (env_flag_r && !(w1c && pwdata_i[`IRCT_BIT_ENV_FLAG]));  // see RULE18
      ca_flag_r  <= ca_wrap  || (ca_flag_r  && !(w1c && pwdata_i[`IRCT_BIT_CA_FLAG]));
    end
  end

  // ==========================================================
  // prescaler, free running, all slower rates are enables
  // six bits reach the divide by 64
  always_ff @(posedge mclk_i) begin
    if (reset_i) pre_r <= '0;
    else         pre_r <= pre_r + (`IRCT_PRE_W)'(1);
  end

  // ==========================================================
  // carrier timer
  // start loads period and compare, then one
  // step per tick; rises on match, falls on
  // wrap: high time is compare value plus one
  // carrier-free mode keeps the compare and
  // reloads only the period; carrier stays inside
  always_ff @(posedge mclk_i) begin
    if (reset_i || !ca_en) begin
      ca_run_r  <= irct_pkg::IRCT_IDLE;     // disable stops and re-arms the start
      ca_cnt_r  <= (reset_i) ? `IRCT_RST_BYTE : ca_cnt_r;
      ca_cmp_r  <= (reset_i) ? `IRCT_RST_BYTE : ca_cmp_r;
      carrier_r <= 1'b0;
      ca_ovf_r  <= 1'b0;
    end else begin
      ca_ovf_r <= ca_wrap;                  // see RULE6
      if (ca_start) begin
        ca_run_r  <= irct_pkg::IRCT_RUN;
        ca_cnt_r  <= ca_period_r;           // see RULE3 RULE12
        if (!level_mode) ca_cmp_r <= ca_high_r;
        carrier_r <= 1'b0;                  // see RULE4
      end else if (ca_wrap) begin
        ca_cnt_r  <= ca_period_r;           // see RULE5 RULE12
        if (!level_mode) ca_cmp_r <= ca_high_r;
        carrier_r <= 1'b0;
      end else if (ca_step) begin
        ca_cnt_r  <= ca_dec;
        if (ca_dec == ca_cmp_r) carrier_r <= 1'b1;   // see RULE4
      end
    end
  end

  // ==========================================================
  // envelope timer; on phase starts first, software loads on count first
  // software loads the off count after each wrap
  // limitation: a mid-phase preload waits for
  // the next wrap
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      env_run_r <= irct_pkg::IRCT_IDLE;
      env_cnt_r <= `IRCT_RST_ENV;
      env_on_r  <= 1'b0;
    end else if (!env_en) begin
      env_run_r <= irct_pkg::IRCT_IDLE;
      env_on_r  <= 1'b0;
    end else if (env_start) begin
      env_run_r <= irct_pkg::IRCT_RUN;
      env_cnt_r <= env_pre_r;
      env_on_r  <= 1'b1;
    end else if (env_wrap) begin
      env_cnt_r <= env_pre_r;               // see RULE18
      env_on_r  <= !env_on_r;               // see RULE9
    end else if (env_step) begin
      env_cnt_r <= env_cnt_r - 12'h001;
    end
  end

  // ==========================================================
  // pin and outputs
  // registered pin: no decode glitch reaches
  // the led, at one clock of lag
  always_ff @(posedge mclk_i) begin
    if (reset_i) pin_r <= 1'b0;
    else         pin_r <= pin_nxt;
  end

  // outputs are plain copies of flops
  assign prdata_o                  = rdata_r;
  assign pready_o                  = ready_r;
  assign pslverr_o                 = err_r;
  assign infrared_transmit_pin_o   = pin_r;
  assign transmit_drive_strength_o = drive_r;
  assign carrier_overflow_o        = ca_ovf_r;
  assign envelope_overflow_flag_o  = env_flag_r;

  // ==========================================================
  // assertions
  // carrier start, wrap, compare and divider
  // sequences shared by the carrier checks
  sequence s_ca_wrap;
    ca_wrap && !ca_start;
  endsequence
  sequence s_reloaded;
    (ca_cnt_r == $past(ca_period_r)) && !carrier_r;
  endsequence
  sequence s_div16_tick;
    ca_en && (ca_sel == 2'h3) && ca_tick;
  endsequence

  AST_CA_START: assert property (@(posedge mclk_i) disable iff (reset_i)  // see RULE3
    ca_start |=> s_reloaded) else $error("carrier start did not load period");
  AST_CA_WRAP: assert property (@(posedge mclk_i) disable iff (reset_i)  // see RULE5
    s_ca_wrap |=> s_reloaded ##0 carrier_overflow_o) else $error("carrier wrap did not reload");
  AST_CA_HIGH: assert property (@(posedge mclk_i) disable iff (reset_i)  // see RULE4
    (ca_step && !ca_wrap && ca_dec == ca_cmp_r) |=> carrier_r) else $error("compare match missed");
  AST_DIV16: assert property (@(posedge mclk_i) disable iff (reset_i)  // see RULE2
    s_div16_tick ##1 (ca_sel == 2'h3) |-> (ca_sel != 2'h3 || !ca_tick)[*8]) else $error("divide by 16 spacing wrong");

  // pin gating
  AST_IR_DIS: assert property (@(posedge mclk_i) disable iff (reset_i)  // see RULE8
    ir_dis_r |=> !infrared_transmit_pin_o) else $error("pin driven while disabled");
  AST_EN_GATE: assert property (@(posedge mclk_i) disable iff (reset_i)  // see RULE7
    (!ca_en && !(env_by_ca && env_en)) |=> !infrared_transmit_pin_o) else $error("pin on while off");
  AST_LEVEL_HIGH: assert property (@(posedge mclk_i) disable iff (reset_i)  // see RULE13
    (level_mode && gate && !ir_dis_r) |=> infrared_transmit_pin_o) else $error("level mode not high");

  // envelope timer
  AST_ENV_WRAP: assert property (@(posedge mclk_i) disable iff (reset_i)  // see RULE18
    env_wrap |=> (env_cnt_r == $past(env_pre_r)) && envelope_overflow_flag_o)
    else $error("envelope wrap did not reload or flag");
  AST_ENV_TOGGLE: assert property (@(posedge mclk_i) disable iff (reset_i)  // see RULE9
    (env_en && !env_start && !env_wrap) |=> $stable(env_on_r)) else $error("envelope toggled off overflow");
  AST_ENV_BY_CA: assert property (@(posedge mclk_i) disable iff (reset_i)  // see RULE23
    (env_en && env_by_ca && env_run_r == irct_pkg::IRCT_RUN && env_cnt_r != `IRCT_ENV_MIN && !ca_wrap)
    |=> $stable(env_cnt_r)) else $error("envelope counted without carrier overflow");

  // carrier-free wrap leaves the compare alone
  AST_FREE_CMP: assert property (@(posedge mclk_i) disable iff (reset_i)  // see RULE12
    (ca_wrap && level_mode) |=> $stable(ca_cmp_r)) else $error("compare reloaded in carrier-free mode");
endmodule

// ==== verification/irct_led_model.sv ====
// Purpose: stand-in for the infrared led driver hanging on the transmit pin
// Assumes: pin is active high, sampled on the rising clock edge
// Notes:   only counts lit cycles; the bench measures duty from the count
`timescale 1ns/100ps
// ==========================================================
// led driver model
module irct_led_model (
  input  wire logic mclk_i,          // block clock
  input  wire logic reset_i,         // synchronous, active high
  input  wire logic led_drive_i,     // transmit pin level
  input  wire logic full_current_i,  // drive strength, 1 full current
  output int        lit_cycles_o,    // cycles the led was lit
  output int        full_cycles_o    // lit cycles at full current
);
  // ==========================================================
  // light counters; an unknown pin never counts as lit
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lit_cycles_o  <= 0;
      full_cycles_o <= 0;
    end else if (led_drive_i === 1'b1) begin
      lit_cycles_o  <= lit_cycles_o + 1;
      full_cycles_o <= full_cycles_o + ((full_current_i === 1'b1) ? 1 : 0);
    end
  end
endmodule

// ==== verification/tb_ir_carrier_envelope_timers.sv ====
// Purpose: self-checking bench of the carrier and envelope timers over apb
// Assumes: byte address is four times the register index, one wait state
// Notes:   duty and rate are measured over whole carrier periods
`timescale 1ns/100ps
`include "irct_params.svh"
// ==========================================================
// bench top
module tb_ir_carrier_envelope_timers;
  logic        mclk_i, reset_i, psel_i, penable_i, pwrite_i;  // clock, reset, apb controls
  logic [11:0] paddr_i;                                         // apb byte address
  logic [31:0] pwdata_i, prdata_o, rdata;                       // apb data, last read
  logic        pready_o, pslverr_o, last_err;                   // apb answer, last error
  logic        ir_pin, drive_full, ca_ovf, env_flag;           // block outputs
  int          lit_cycles, full_cycles, error_cnt, checks, cyc; // counters
  int          ov, div;                                         // measured overflows, divider under test
  // ==========================================================
  // design, partner and clock
  irct_top uut (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .infrared_transmit_pin_o(ir_pin),
    .transmit_drive_strength_o(drive_full), .carrier_overflow_o(ca_ovf),
    .envelope_overflow_flag_o(env_flag));
  irct_led_model led (.mclk_i(mclk_i), .reset_i(reset_i), .led_drive_i(ir_pin),
    .full_current_i(drive_full), .lit_cycles_o(lit_cycles), .full_cycles_o(full_cycles));
  always #20 mclk_i = ~mclk_i;
  // ==========================================================
  // reporting
  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_cnt(input string what, input int exp, input int got);
    checks++;
    if (got != exp) begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      final_report();
    end
  end
  // ==========================================================
  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= {2'h0, idx, 2'h0};
    pwdata_i  <= {24'h000000, wd};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    rdata    = prdata_o;
    last_err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);  // idle edge: the write has landed before any check
  endtask
  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    cmp(what, {24'h000000, exp}, rdata);
  endtask
  // pin high cycles and carrier overflows over n edges
  task automatic measure(input int n, input int exp_hi, input int exp_ov);
    int s;
    s  = lit_cycles;
    ov = 0;
    repeat (n) begin
      @(posedge mclk_i);
      if (ca_ovf === 1'b1) ov++;
    end
    cmp_cnt("pin high cycles", exp_hi, lit_cycles - s);
    cmp_cnt("carrier overflows", exp_ov, ov);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    mclk_i = 1'b0; reset_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 12'h000; pwdata_i = 32'h00000000; error_cnt = 0; checks = 0; cyc = 0;
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    // every register clears to zero
    for (int i = 8'h20; i <= 8'h29; i++) rd_chk("reset value", i[7:0], 8'h00);
    rd_chk("disable reset", `IRCT_IDX_IR_CTRL, 8'h00);
    rd_chk("drive reset", `IRCT_IDX_DRIVE, 8'h00);
    // unmapped place: error, write ignored, read zero
    apb(1'b1, 8'h2A, 8'hFF);
    cmp("unmapped write error", 32'h1, {31'h0, last_err});
    rd_chk("unmapped read", 8'h2A, 8'h00);
    cmp("unmapped read error", 32'h1, {31'h0, last_err});
    apb(1'b1, `IRCT_IDX_CA_HIGH, 8'hA5);
    rd_chk("high pulse readback", `IRCT_IDX_CA_HIGH, 8'hA5);
    // period 0F, high 08: nine of sixteen counts high
    apb(1'b1, `IRCT_IDX_CA_CNT, 8'h0F);
    apb(1'b1, `IRCT_IDX_CA_HIGH, 8'h08);
    apb(1'b1, `IRCT_IDX_CA_CTRL, 8'h80);
    repeat (8) @(posedge mclk_i);
    measure(64, 0, 0);
    apb(1'b1, `IRCT_IDX_MODE, 8'h80);
    // each carrier clock choice; a window of 512 holds whole periods
    for (int s = 0; s < 4; s++) begin
      div = (s == 3) ? 16 : (1 << s);
      apb(1'b1, `IRCT_IDX_CA_CTRL, 8'h00);
      apb(1'b1, `IRCT_IDX_CA_CTRL, 8'h80 | (s[7:0] << 4));
      repeat (8) @(posedge mclk_i);
      measure(512, 288, 512 / (16 * div));
    end
    // carrier-free: level high while enabled, counter still wraps
    apb(1'b1, `IRCT_IDX_CA_CTRL, 8'h00);
    apb(1'b1, `IRCT_IDX_CA_CTRL, 8'h81);
    repeat (8) @(posedge mclk_i);
    measure(64, 64, 4);
    apb(1'b1, `IRCT_IDX_CA_CTRL, 8'h01);
    repeat (8) @(posedge mclk_i);
    measure(64, 0, 0);
    // output disable silences a running carrier
    apb(1'b1, `IRCT_IDX_CA_CTRL, 8'h80);
    apb(1'b1, `IRCT_IDX_IR_CTRL, 8'h40);
    repeat (8) @(posedge mclk_i);
    measure(64, 0, 4);
    apb(1'b1, `IRCT_IDX_IR_CTRL, 8'h00);
    // drive strength follows its bit
    apb(1'b1, `IRCT_IDX_DRIVE, 8'h08);
    cmp("drive strength", 32'h1, {31'h0, drive_full});
    apb(1'b1, `IRCT_IDX_DRIVE, 8'h00);
    cmp("drive strength", 32'h0, {31'h0, drive_full});
    // envelope on the carrier: four carrier periods on, four off
    apb(1'b1, `IRCT_IDX_ENV_LO, 8'h03);
    apb(1'b1, `IRCT_IDX_ENV_HI, 8'h00);
    apb(1'b1, `IRCT_IDX_ENV_CTRL, 8'hB0);
    repeat (20) @(posedge mclk_i);
    measure(256, 72, 16);
    cmp("envelope flag", 32'h1, {31'h0, env_flag});
    apb(1'b1, `IRCT_IDX_ENV_CTRL, 8'h00);
    apb(1'b1, `IRCT_IDX_CA_CTRL, 8'h00);
    // oscillator-derived envelope clocks: sixteen-tick wrap timing
    for (int s = 0; s < 3; s++) begin
      div = (s == 0) ? 1 : ((s == 1) ? 4 : 64);
      apb(1'b1, `IRCT_IDX_ENV_CTRL, 8'h00);
      apb(1'b1, `IRCT_IDX_STATUS, 8'h01);
      cmp("envelope flag cleared", 32'h0, {31'h0, env_flag});
      apb(1'b1, `IRCT_IDX_ENV_LO, 8'h0F);
      apb(1'b1, `IRCT_IDX_ENV_CTRL, 8'h80 | (s[7:0] << 4));
      repeat (8 * div) @(posedge mclk_i);
      cmp("envelope flag early", 32'h0, {31'h0, env_flag});
      repeat (16 * div) @(posedge mclk_i);
      cmp("envelope flag late", 32'h1, {31'h0, env_flag});
    end
    final_report();
  end
endmodule
